/* File: verilog/converter_config_registers.sv */
`timescale 1ns/10ps
`include "converter_config_defines.svh"

// Contract
// - offset 0x00 returns fixed vendor code, read-only
// - rate bits 3:2 select voltage ramp rate
// - rate bits 1:0 select switching frequency
// - ramp field resets to 10b
// - frequency field resets to 10b
// - offset 0x02 bits 6:0 code, bit7 reserved
module converter_config_registers #(
   parameter logic [6:0] BUS_ADDRESS = 7'h3E, // arbitrary
   parameter logic [7:0] VENDOR_CODE = 8'h5A // arbitrary
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [7:0] converter_flags,
   output logic [1:0] voltage_ramp_rate,
   output logic [1:0] switching_rate_select,
   output logic [6:0] output_voltage_code,
   output logic [7:0] converter_control,
   output logic [7:0] converter_settings
);

   converter_config_pkg::slave_state_type state;
   logic scl_prev;
   logic sda_prev;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] ptr;
   logic rw;
   logic master_ack;

   // bus events, pins taken as synchronous to sys_clk
   wire scl_rise = scl_in & ~scl_prev;
   wire scl_fall = ~scl_in & scl_prev;
   wire start_seen = scl_in & scl_prev & sda_prev & ~sda_in;
   wire stop_seen = scl_in & scl_prev & ~sda_prev & sda_in;
   wire byte_full = (bit_cnt == `BYTE_BITS);
   wire receiving = (state == converter_config_pkg::st_addr) |
                    (state == converter_config_pkg::st_ptr) |
                    (state == converter_config_pkg::st_wdata);
   wire addr_match = (shreg[7:1] == BUS_ADDRESS);
   wire wr_en = scl_fall & byte_full & (state == converter_config_pkg::st_wdata);
   wire load_rd = scl_fall & ((state == converter_config_pkg::st_addr_ack & rw) |
                  (state == converter_config_pkg::st_rdata_ack & master_ack));

   // read mux; unmapped offsets read as zero
   wire [7:0] rd_data =
      (ptr == `REG_VENDOR) ? VENDOR_CODE :
      (ptr == `REG_RATE) ? {4'h0, voltage_ramp_rate, switching_rate_select} :
      (ptr == `REG_LEVEL) ? {1'b0, output_voltage_code} :
      (ptr == `REG_CTRL) ? converter_control :
      (ptr == `REG_FLAGS) ? converter_flags :
      (ptr == `REG_SETTINGS) ? converter_settings : 8'h00;

   // open drain: only ever pull low, for acks and zero read bits
   assign sda_out = 1'b0;
   assign sda_oe = (state == converter_config_pkg::st_addr_ack) |
                   (state == converter_config_pkg::st_ptr_ack) |
                   (state == converter_config_pkg::st_wdata_ack) |
                   ((state == converter_config_pkg::st_rdata) & ~shreg[7]);

   // pin history for edge and start/stop detection
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_in;
         sda_prev <= sda_in;
      end
   end

   // serial slave sequencer; start and stop override any bit activity
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= converter_config_pkg::st_idle;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'b0;
         master_ack <= 1'b0;
      end else if (start_seen) begin
         state <= converter_config_pkg::st_addr;
         bit_cnt <= 4'h0;
      end else if (stop_seen) begin
         state <= converter_config_pkg::st_idle;
      end else if (scl_rise) begin
         if (receiving) begin
            shreg <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
         end else if (state == converter_config_pkg::st_rdata) begin
            bit_cnt <= bit_cnt + 4'h1;
         end else if (state == converter_config_pkg::st_rdata_ack) begin
            master_ack <= ~sda_in;
         end
      end else if (scl_fall) begin
         unique case (state)
            converter_config_pkg::st_idle: begin
               state <= converter_config_pkg::st_idle;
            end
            converter_config_pkg::st_addr: begin
               if (byte_full) begin
                  rw <= shreg[0];
                  state <= addr_match ? converter_config_pkg::st_addr_ack :
                                        converter_config_pkg::st_idle;
               end
            end
            converter_config_pkg::st_addr_ack: begin
               bit_cnt <= 4'h0;
               if (rw) begin
                  shreg <= rd_data;
                  ptr <= ptr + 8'h01;
                  state <= converter_config_pkg::st_rdata;
               end else begin
                  state <= converter_config_pkg::st_ptr;
               end
            end
            converter_config_pkg::st_ptr: begin
               if (byte_full) begin
                  ptr <= shreg;
                  state <= converter_config_pkg::st_ptr_ack;
               end
            end
            converter_config_pkg::st_ptr_ack: begin
               bit_cnt <= 4'h0;
               state <= converter_config_pkg::st_wdata;
            end
            converter_config_pkg::st_wdata: begin
               if (byte_full) begin
                  state <= converter_config_pkg::st_wdata_ack;
               end
            end
            converter_config_pkg::st_wdata_ack: begin
               bit_cnt <= 4'h0;
               ptr <= ptr + 8'h01;
               state <= converter_config_pkg::st_wdata;
            end
            converter_config_pkg::st_rdata: begin
               if (byte_full) begin
                  state <= converter_config_pkg::st_rdata_ack;
               end else begin
                  shreg <= {shreg[6:0], 1'b0};
               end
            end
            converter_config_pkg::st_rdata_ack: begin
               bit_cnt <= 4'h0;
               if (master_ack) begin
                  shreg <= rd_data;
                  ptr <= ptr + 8'h01;
                  state <= converter_config_pkg::st_rdata;
               end else begin
                  state <= converter_config_pkg::st_idle;
               end
            end
         endcase
      end
   end

   // register writes; vendor and flag offsets have no storage
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         voltage_ramp_rate <= `RAMP_RST;
         switching_rate_select <= `SWITCH_RST;
         output_voltage_code <= `LEVEL_RST;
         converter_control <= `CTRL_RST;
         converter_settings <= `SETTINGS_RST;
      end else if (wr_en) begin
         if (ptr == `REG_RATE) begin
            voltage_ramp_rate <= shreg[`RAMP_MSB:`RAMP_LSB];
            switching_rate_select <= shreg[`SWITCH_MSB:`SWITCH_LSB];
         end
         if (ptr == `REG_LEVEL) begin
            output_voltage_code <= shreg[6:0];
         end
         if (ptr == `REG_CTRL) begin
            converter_control <= shreg;
         end
         if (ptr == `REG_SETTINGS) begin
            converter_settings <= shreg;
         end
      end
   end

   // checks; the reset ones deliberately run without a disable
   property p_vendor_read;
      @(posedge sys_clk) disable iff (rst)
      load_rd && ptr == `REG_VENDOR |=> shreg == VENDOR_CODE && sda_oe == ~VENDOR_CODE[7];
   endproperty
   a_vendor_read: assert property (p_vendor_read) else $error("vendor code misread");

   property p_ramp_write;
      @(posedge sys_clk) disable iff (rst)
      wr_en && ptr == `REG_RATE |=> voltage_ramp_rate == $past(shreg[3:2]);
   endproperty
   a_ramp_write: assert property (p_ramp_write) else $error("ramp field not stored");

   property p_switch_write;
      @(posedge sys_clk) disable iff (rst)
      wr_en && ptr == `REG_RATE |=> switching_rate_select == $past(shreg[1:0]);
   endproperty
   a_switch_write: assert property (p_switch_write) else $error("frequency field not stored");

   property p_ramp_reset;
      @(posedge sys_clk) rst |=> voltage_ramp_rate == 2'h2;
   endproperty
   a_ramp_reset: assert property (p_ramp_reset) else $error("ramp reset value wrong");

   property p_switch_reset;
      @(posedge sys_clk) rst |=> switching_rate_select == 2'h2;
   endproperty
   a_switch_reset: assert property (p_switch_reset) else $error("frequency reset value wrong");

   property p_rate_upper_zero;
      @(posedge sys_clk) disable iff (rst)
      load_rd && ptr == `REG_RATE |=> shreg[7:4] == 4'h0 ##1 $stable(voltage_ramp_rate);
   endproperty
   a_rate_upper_zero: assert property (p_rate_upper_zero) else $error("rate upper bits set");

   property p_level_write;
      @(posedge sys_clk) disable iff (rst)
      wr_en && ptr == `REG_LEVEL |=> output_voltage_code == $past(shreg[6:0]);
   endproperty
   a_level_write: assert property (p_level_write) else $error("voltage code not stored");

   property p_level_read;
      @(posedge sys_clk) disable iff (rst)
      load_rd && ptr == `REG_LEVEL |=> shreg == {1'b0, output_voltage_code};
   endproperty
   a_level_read: assert property (p_level_read) else $error("voltage code misread");

   c_write: cover property (@(posedge sys_clk) disable iff (rst) wr_en && ptr == `REG_RATE);
   c_read: cover property (@(posedge sys_clk) disable iff (rst) load_rd && ptr == `REG_VENDOR);
   c_nack: cover property (@(posedge sys_clk) disable iff (rst)
      scl_fall && state == converter_config_pkg::st_rdata_ack && !master_ack);

endmodule

/* File: verilog/converter_config_defines.svh */
`ifndef CONVERTER_CONFIG_DEFINES_SVH
`define CONVERTER_CONFIG_DEFINES_SVH

// register offsets
`define REG_VENDOR 8'h00
`define REG_RATE 8'h01
`define REG_LEVEL 8'h02
`define REG_CTRL 8'h03
`define REG_FLAGS 8'h04
`define REG_SETTINGS 8'h05

// reset values
`define RAMP_RST 2'h2
`define SWITCH_RST 2'h2
`define LEVEL_RST 7'h28
`define CTRL_RST 8'h0A
`define SETTINGS_RST 8'hA4

// field positions inside the rate register
`define RAMP_MSB 3
`define RAMP_LSB 2
`define SWITCH_MSB 1
`define SWITCH_LSB 0

// serial byte length in bits
`define BYTE_BITS 4'h8

`endif

/* File: verilog/converter_config_pkg.sv */
package converter_config_pkg;

   // one-hot serial slave states
   typedef enum logic [8:0] {
      st_idle = 9'h001,
      st_addr = 9'h002,
      st_addr_ack = 9'h004,
      st_ptr = 9'h008,
      st_ptr_ack = 9'h010,
      st_wdata = 9'h020,
      st_wdata_ack = 9'h040,
      st_rdata = 9'h080,
      st_rdata_ack = 9'h100
   } slave_state_type;

endpackage

/* File: sim/i2c_host_model.sv */
`timescale 1ns/10ps

// bus master: drives scl, open-drain sda with a pull-up
module i2c_host_model (
   input wire logic sys_clk,
   input wire logic dev_oe,
   output logic scl,
   output logic sda
);
   logic drv = 1'b1;
   logic smp;
   logic ok;
   int q = 4; // cycles per third of a bit, raise to slow the bus
   logic [7:0] rbuf [0:7];

   // wired-and: low while either side pulls
   assign sda = drv & ~dev_oe;
   initial scl = 1'b1;

   task automatic w;
      repeat (q) @(negedge sys_clk);
   endtask

   // sda settles a full third of a bit before scl rises, sampled just before fall
   task automatic bitc;
      w();
      scl = 1'b1;
      w();
      smp = sda;
      scl = 1'b0;
      w();
   endtask

   task automatic start;
      drv = 1'b1;
      w();
      scl = 1'b1;
      w();
      drv = 1'b0;
      w();
      scl = 1'b0;
      w();
   endtask

   task automatic stop;
      drv = 1'b0;
      w();
      scl = 1'b1;
      w();
      drv = 1'b1;
      w();
   endtask

   task automatic tx(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         drv = b[i];
         bitc();
      end
      drv = 1'b1;
      bitc();
      ok = ok & ~smp;
   endtask

   // last byte of a read is refused so the slave lets go of sda
   task automatic rx(input logic nack, output logic [7:0] b);
      drv = 1'b1;
      for (int i = 0; i < 8; i++) begin
         bitc();
         b = {b[6:0], smp};
      end
      drv = nack;
      bitc();
      drv = 1'b1;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
      ok = 1'b1;
      start();
      tx({a, 1'b0});
      tx(p);
      tx(d);
      stop();
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n);
      ok = 1'b1;
      start();
      tx({a, 1'b0});
      tx(p);
      start();
      tx({a, 1'b1});
      for (int i = 0; i < n; i++)
         rx(i == n - 1, rbuf[i]);
      stop();
   endtask
endmodule

/* File: sim/converter_config_registers_test.sv */
`timescale 1ns/10ps

module converter_config_registers_test;
   localparam logic [6:0] addr = 7'h3E;
   localparam logic [7:0] vend = 8'hC3; // arbitrary
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] flags = 8'hA5;
   logic scl, sda, sda_oe;
   logic [1:0] ramp, sw_rate;
   logic [6:0] code;
   logic [7:0] ctrl, settings;
   logic sda_low;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;

   always #25 sys_clk = ~sys_clk;

   // the sequence needs about 8000 cycles, so this only trips on a hang
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         results();
      end
   end

   converter_config_registers #(.BUS_ADDRESS(addr), .VENDOR_CODE(vend)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_low),
      .sda_oe(sda_oe), .converter_flags(flags), .voltage_ramp_rate(ramp),
      .switching_rate_select(sw_rate), .output_voltage_code(code),
      .converter_control(ctrl), .converter_settings(settings));

   i2c_host_model u_host (.sys_clk(sys_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task automatic results;
      $display("TB: %0d mismatches, %0d compared", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      logic [1:0] v;
      logic [7:0] exp_tab [0:5];
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      chk({6'h0, ramp}, 8'h02);
      chk({6'h0, sw_rate}, 8'h02);
      chk({1'b0, code}, 8'h28);
      chk(ctrl, 8'h0A);
      chk(settings, 8'hA4);
      chk({7'h0, sda_low}, 8'h00);
      // burst read over the whole map checks reset values and auto-increment
      exp_tab = '{vend, 8'h0A, 8'h28, 8'h0A, 8'hA5, 8'hA4};
      u_host.rd(addr, 8'h00, 6);
      chk({7'h0, u_host.ok}, 8'h01);
      for (int i = 0; i < 6; i++)
         chk(u_host.rbuf[i], exp_tab[i]);
      // vendor code ignores writes; slow bus on this one
      u_host.q = 7;
      u_host.wr(addr, 8'h00, 8'hFF);
      u_host.q = 4;
      u_host.rd(addr, 8'h00, 1);
      chk(u_host.rbuf[0], vend);
      // every ramp and frequency code, with junk in the upper nibble
      for (int i = 0; i < 4; i++) begin
         v = 2'(i);
         u_host.wr(addr, 8'h01, {4'hF, v, ~v});
         chk({6'h0, ramp}, {6'h0, v});
         chk({6'h0, sw_rate}, {6'h0, ~v});
         u_host.rd(addr, 8'h01, 1);
         chk(u_host.rbuf[0], {4'h0, v, ~v});
      end
      // reserved top bit of the voltage code
      u_host.wr(addr, 8'h02, 8'hFF);
      chk({1'b0, code}, 8'h7F);
      u_host.rd(addr, 8'h02, 1);
      chk(u_host.rbuf[0], 8'h7F);
      // burst write over control, read-only flags and settings, then read back
      u_host.ok = 1'b1;
      u_host.start();
      u_host.tx({addr, 1'b0});
      u_host.tx(8'h03);
      u_host.tx(8'h5C);
      u_host.tx(8'h00);
      u_host.tx(8'h3B);
      u_host.stop();
      chk({7'h0, u_host.ok}, 8'h01);
      chk(ctrl, 8'h5C);
      chk(settings, 8'h3B);
      u_host.rd(addr, 8'h03, 4);
      chk(u_host.rbuf[0], 8'h5C);
      chk(u_host.rbuf[1], 8'hA5);
      chk(u_host.rbuf[2], 8'h3B);
      chk(u_host.rbuf[3], 8'h00);
      // foreign address gets no ack and changes nothing
      u_host.wr(addr ^ 7'h01, 8'h01, 8'h00);
      chk({7'h0, u_host.ok}, 8'h00);
      chk({6'h0, ramp}, 8'h03);
      // second reset in mid-run restores the defaults
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      chk({6'h0, ramp}, 8'h02);
      chk({6'h0, sw_rate}, 8'h02);
      chk({1'b0, code}, 8'h28);
      chk(ctrl, 8'h0A);
      chk(settings, 8'hA4);
      results();
   end
endmodule
